// *** smtc_pkg.sv ***
package smtc_pkg;
	// Clock and timing
	localparam int CLK_NS = 50;
	localparam int CLR_FILT_NS = 200;
	localparam int CLR_FILT_CYC = (CLR_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRB_LOW_NS = 100;
	localparam int STRB_LOW_CYC = (STRB_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_LOW_NS = 250;
	localparam int RD_LOW_CYC = (RD_LOW_NS + CLK_NS - 1) / CLK_NS;
	// System cycles after reset in which the link is not yet trusted
	localparam int LINK_QUIET_CYC = 12;
	// Widths and bit positions
	localparam int DATA_W = 18;
	localparam int CTRL_W = 6;
	localparam int SPI_CLK_BIT = 5;
	localparam int SPI_DAT_BIT = 4;
	localparam int SLV_SCLK_BIT = 6;
	localparam int SLV_SERIAL_WRITE_DATA_BIT = 7;
	localparam int FRAME_W = 29;
	// Pin encodings
	localparam logic ROLE_SLAVE = 1'h0;
	localparam logic ROLE_MASTER = 1'h1;
	localparam logic PORT_SPI = 1'h0;
	localparam logic PORT_PAR = 1'h1;
	localparam logic DIR_READ = 1'h1;
	localparam logic DIR_WRITE = 1'h0;
	// Frame kinds carried on the link
	typedef enum logic [2:0] {
		K_WRITE = 3'h0,
		K_SPI = 3'h1,
		K_RDDATA = 3'h2,
		K_RDCTRL = 3'h3,
		K_SLEEP = 3'h6,
		K_WAKE = 3'h7
	} smtc_kind_e;
	// Eight control bits: strobe select, direction, control lines
	typedef struct packed {
		logic sel;
		logic dir;
		logic [CTRL_W-1:0] lines;
	} smtc_ctrl_s;
	typedef struct packed {
		smtc_kind_e kind;
		smtc_ctrl_s ctrl;
		logic [DATA_W-1:0] data;
	} smtc_frame_s;
	// All sampled pins
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [CTRL_W-1:0] lines;
		logic dir;
		logic strobe_in_1;
		logic strobe_in_0;
		logic role;
		logic port;
		logic sel;
		logic clear_n;
		logic lowpwr_n;
	} smtc_pins_s;
	typedef enum logic [1:0] {
		MODE_RESET = 2'h0,
		MODE_OPER = 2'h1,
		MODE_LOW_POWER_REQUEST_N = 2'h3
	} smtc_mode_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_STROBE = 2'h1,
		ST_READ = 2'h3,
		ST_DRIVE = 2'h2
	} smtc_state_e;
endpackage

// *** smtc_link.sv ***
`timescale 1ns/1ns
module smtc_link (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic link_clk_i, // Serial link clock
	input wire logic tx_valid_i, // Frame offered
	input wire smtc_pkg::smtc_frame_s tx_word_i, // Frame to send
	output logic tx_ready_o, // Transmitter free
	output logic rx_valid_o, // Pulse: frame received
	output smtc_pkg::smtc_frame_s rx_word_o, // Last frame received
	input wire logic link_data_i, // Serial data in
	output logic link_data_o // Serial data out
);
	localparam int FW = smtc_pkg::FRAME_W;
	localparam logic [4:0] LAST = 5'(FW - 1);
	localparam logic [3:0] QUIET = 4'(smtc_pkg::LINK_QUIET_CYC);
	typedef struct packed {
		smtc_pkg::smtc_frame_s hold;
		logic req;
		logic ack_s1;
		logic ack_s2;
		logic rx_s1;
		logic rx_s2;
		logic rx_seen;
		logic [3:0] quiet;
	} smtc_lsys_s;
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic req_s1;
		logic req_s2;
		logic ack;
		logic busy;
		logic [4:0] cnt;
		logic [FW-1:0] sh;
		logic out;
		logic rbusy;
		logic [4:0] rcnt;
		logic [FW-1:0] rsh;
		smtc_pkg::smtc_frame_s rword;
		logic rtgl;
	} smtc_llnk_s;
	smtc_lsys_s s, next_s;
	smtc_llnk_s l, next_l;

	// System side: request toggle out, acknowledge and receive toggles in
	always_comb begin
		next_s = s;
		next_s.ack_s1 = l.ack;
		next_s.ack_s2 = s.ack_s1;
		next_s.rx_s1 = l.rtgl;
		next_s.rx_s2 = s.rx_s1;
		next_s.rx_seen = s.rx_s2;
		// Hold off both directions until the link side has settled
		next_s.quiet = (s.quiet == 4'h0) ? 4'h0 : 4'(s.quiet - 4'h1);
		if (tx_valid_i && tx_ready_o) begin
			next_s.hold = tx_word_i;
			next_s.req = ~s.req;
		end
		if (!rst_n_i) begin
			next_s.req = 1'h0;
			next_s.hold = '0;
			next_s.quiet = QUIET;
		end
	end

	assign tx_ready_o = (s.quiet == 4'h0) && (s.req == s.ack_s2);
	assign rx_valid_o = (s.quiet == 4'h0) && (s.rx_s2 != s.rx_seen);
	assign rx_word_o = l.rword;
	assign link_data_o = l.out;

	// Link side: start bit then frame MSB first, and the mirror receiver
	always_comb begin
		next_l = l;
		next_l.rst_s1 = rst_n_i;
		next_l.rst_s2 = l.rst_s1;
		next_l.req_s1 = s.req;
		next_l.req_s2 = l.req_s1;
		next_l.out = 1'h0;
		if (l.busy) begin
			next_l.out = l.sh[FW-1];
			next_l.sh = {l.sh[FW-2:0], 1'h0};
			next_l.cnt = 5'(l.cnt + 5'h1);
			if (l.cnt == LAST) begin
				next_l.busy = 1'h0;
				next_l.ack = l.req_s2;
			end
		end else if (l.req_s2 != l.ack) begin
			next_l.busy = 1'h1;
			next_l.out = 1'h1;
			next_l.sh = s.hold;
			next_l.cnt = 5'h0;
		end
		if (l.rbusy) begin
			next_l.rsh = {l.rsh[FW-2:0], link_data_i};
			next_l.rcnt = 5'(l.rcnt + 5'h1);
			if (l.rcnt == LAST) begin
				next_l.rbusy = 1'h0;
				next_l.rword = {l.rsh[FW-2:0], link_data_i};
				next_l.rtgl = ~l.rtgl;
			end
		end else if (link_data_i) begin
			next_l.rbusy = 1'h1;
			next_l.rcnt = 5'h0;
		end
		if (!l.rst_s2) begin
			next_l.ack = l.req_s2;
			next_l.busy = 1'h0;
			next_l.out = 1'h0;
			next_l.rbusy = 1'h0;
			next_l.rtgl = 1'h0;
			next_l.cnt = 5'h0;
			next_l.rcnt = 5'h0;
		end
	end

	// State registers of the two domains
	always_ff @(posedge sys_clk_i) begin
		s <= next_s;
	end

	always_ff @(posedge link_clk_i) begin
		l <= next_l;
	end
endmodule // smtc_link

// *** smtc_mode_ctrl.sv ***
`timescale 1ns/1ns
module smtc_mode_ctrl (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic link_clk_i, // Serial link clock
	input wire logic link_data_i, // Link data in
	output logic link_data_o, // Link data out
	input wire logic role_select_i, // 1 master, 0 slave
	input wire logic chip_clear_n_i, // Device reset, active low
	input wire logic low_power_request_n_i, // Standby request, active low
	input wire logic port_mode_select_i, // 1 parallel, 0 SPI
	input wire logic strobe_source_select_i, // Strobe channel select
	input wire logic strobe_in_0_i, // Strobe channel 0
	input wire logic strobe_in_1_i, // Strobe channel 1
	output logic strobe_out_0_o, // Strobe out channel 0
	output logic strobe_out_1_o, // Strobe out channel 1
	output logic [1:0] strobe_out_oe_n_o, // Strobe enables, low drives
	input wire logic [17:0] parallel_data_bus_i, // Data pins in
	output logic [17:0] parallel_data_bus_o, // Data pins out
	output logic [17:0] parallel_data_bus_oe_n_o, // Data enables, low drives
	input wire logic [5:0] control_lines_i, // Control pins in
	output logic [5:0] control_lines_o, // Control pins out
	output logic [5:0] control_lines_oe_n_o, // Control enables, low drives
	input wire logic rw_dir_i, // Direction pin in
	output logic rw_dir_o, // Direction pin out
	output logic rw_dir_oe_n_o, // Direction enable, low drives
	output smtc_pkg::smtc_mode_e mode_o // Current mode
);
	localparam logic [3:0] FILT_LAST = 4'(smtc_pkg::CLR_FILT_CYC - 1);
	localparam logic [3:0] STRB_LAST = 4'(smtc_pkg::STRB_LOW_CYC - 1);
	localparam logic [3:0] RD_LAST = 4'(smtc_pkg::RD_LOW_CYC - 1);
	typedef struct packed {
		smtc_pkg::smtc_pins_s s1;
		smtc_pkg::smtc_pins_s s2;
		logic act_prev;
		logic [3:0] fcnt;
		logic clr_act;
		smtc_pkg::smtc_mode_e mode;
		logic role;
		logic port;
		logic sel;
		smtc_pkg::smtc_state_e st;
		logic [3:0] tcnt;
		logic told;
		logic [17:0] pd;
		logic [5:0] pc;
		logic pdir;
		logic [1:0] strb;
		logic ch;
	} smtc_core_s;
	smtc_core_s r, next_r;
	smtc_pkg::smtc_pins_s pins_in;
	smtc_pkg::smtc_frame_s tx_word, rx_word;
	logic tx_valid, tx_ready, rx_valid;
	logic act, fell, rose, spi_sel, sleep_due;

	// Selected strobe level for a given pin sample and configuration
	function automatic logic act_strobe(smtc_pkg::smtc_pins_s p, logic port, logic sel);
		if (port == smtc_pkg::PORT_SPI && !sel) begin
			return p.lines[smtc_pkg::SPI_CLK_BIT];
		end
		return sel ? p.strobe_in_1 : p.strobe_in_0;
	endfunction

	assign pins_in = '{data: parallel_data_bus_i, lines: control_lines_i,
		dir: rw_dir_i, strobe_in_1: strobe_in_1_i, strobe_in_0: strobe_in_0_i,
		role: role_select_i, port: port_mode_select_i,
		sel: strobe_source_select_i, clear_n: chip_clear_n_i,
		lowpwr_n: low_power_request_n_i};

	smtc_link u_link (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.link_clk_i(link_clk_i),
		.tx_valid_i(tx_valid),
		.tx_word_i(tx_word),
		.tx_ready_o(tx_ready),
		.rx_valid_o(rx_valid),
		.rx_word_o(rx_word),
		.link_data_i(link_data_i),
		.link_data_o(link_data_o)
	);

	// Strobe edges on the synchronised pins
	assign act = act_strobe(r.s2, r.port, r.sel);
	assign fell = r.act_prev && !act;
	assign rose = !r.act_prev && act;
	assign spi_sel = (r.port == smtc_pkg::PORT_SPI) && !r.sel;
	assign sleep_due = r.role && (r.told != (r.mode == smtc_pkg::MODE_LOW_POWER_REQUEST_N));

	// Next state: filter, modes, master and slave sequences
	always_comb begin
		next_r = r;
		tx_valid = 1'h0;
		tx_word = '0;
		next_r.s1 = pins_in;
		next_r.s2 = r.s1;
		next_r.act_prev = act;
		// Clear needs a long low run before it acts
		if (r.s2.clear_n) begin
			next_r.fcnt = 4'h0;
			next_r.clr_act = 1'h0;
		end else if (r.fcnt == FILT_LAST) begin
			next_r.clr_act = 1'h1;
		end else begin
			next_r.fcnt = 4'(r.fcnt + 4'h1);
		end
		if (r.clr_act || r.mode == smtc_pkg::MODE_RESET) begin
			// Configuration is latched only while in reset
			next_r.role = r.s2.role;
			next_r.port = r.s2.port;
			next_r.sel = r.s2.sel;
		end
		if (r.clr_act) begin
			next_r.mode = smtc_pkg::MODE_RESET;
			next_r.st = smtc_pkg::ST_IDLE;
			next_r.told = 1'h0;
			next_r.pd = '0;
			next_r.pc = '0;
			next_r.pdir = smtc_pkg::DIR_WRITE;
			next_r.strb = 2'h3;
		end else if (r.role == smtc_pkg::ROLE_MASTER) begin
			next_r.mode = r.s2.lowpwr_n ? smtc_pkg::MODE_OPER : smtc_pkg::MODE_LOW_POWER_REQUEST_N;
			if (r.mode != smtc_pkg::MODE_OPER) begin
				next_r.st = smtc_pkg::ST_IDLE;
			end
			tx_word.ctrl = '{sel: r.sel, dir: r.s2.dir, lines: r.s2.lines};
			if (sleep_due) begin
				// Standby command to the slave goes first
				tx_valid = tx_ready;
				tx_word.kind = r.told ? smtc_pkg::K_WAKE : smtc_pkg::K_SLEEP;
				if (tx_ready) begin
					next_r.told = ~r.told;
				end
			end else if (r.mode == smtc_pkg::MODE_OPER) begin
				case (r.st)
					smtc_pkg::ST_IDLE: begin
						if (spi_sel) begin
							// SPI write: control bits and chip select
							tx_valid = rose && tx_ready;
							tx_word.kind = smtc_pkg::K_SPI;
							tx_word.data[0] = r.s2.strobe_in_0;
						end else if (fell && tx_ready) begin
							tx_valid = 1'h1;
							if (r.s2.dir == smtc_pkg::DIR_READ) begin
								tx_word.kind = smtc_pkg::K_RDCTRL;
								next_r.st = smtc_pkg::ST_READ;
							end else begin
								tx_word.kind = smtc_pkg::K_WRITE;
								tx_word.data = r.s2.data;
							end
						end
					end
					smtc_pkg::ST_READ: begin
						if (rx_valid && rx_word.kind == smtc_pkg::K_RDDATA) begin
							next_r.pd = rx_word.data;
							next_r.st = smtc_pkg::ST_DRIVE;
						end
					end
					smtc_pkg::ST_DRIVE: begin
						if (rose) begin
							next_r.st = smtc_pkg::ST_IDLE;
						end
					end
					default: begin
						next_r.st = smtc_pkg::ST_IDLE;
					end
				endcase
			end
		end else begin
			// Slave: standby follows link commands, never the local request pin
			if (r.mode == smtc_pkg::MODE_RESET) begin
				next_r.mode = smtc_pkg::MODE_OPER;
			end else if (rx_valid && rx_word.kind == smtc_pkg::K_SLEEP) begin
				next_r.mode = smtc_pkg::MODE_LOW_POWER_REQUEST_N;
				next_r.st = smtc_pkg::ST_IDLE;
				next_r.strb = 2'h3;
			end else if (rx_valid && rx_word.kind == smtc_pkg::K_WAKE) begin
				next_r.mode = smtc_pkg::MODE_OPER;
			end else if (r.mode == smtc_pkg::MODE_OPER) begin
				case (r.st)
					smtc_pkg::ST_IDLE: begin
						if (rx_valid) begin
							next_r.pc = rx_word.ctrl.lines;
							next_r.pdir = rx_word.ctrl.dir;
							next_r.ch = rx_word.ctrl.sel;
							next_r.tcnt = 4'h0;
							if (rx_word.kind == smtc_pkg::K_SPI) begin
								// Clock and data mirrored onto data pins
								next_r.pd[smtc_pkg::SLV_SCLK_BIT] =
									rx_word.ctrl.lines[smtc_pkg::SPI_CLK_BIT];
								next_r.pd[smtc_pkg::SLV_SERIAL_WRITE_DATA_BIT] =
									rx_word.ctrl.lines[smtc_pkg::SPI_DAT_BIT];
								next_r.strb[0] = rx_word.data[0];
							end else if (rx_word.kind == smtc_pkg::K_WRITE) begin
								next_r.pd = rx_word.data;
								next_r.strb[rx_word.ctrl.sel] = 1'h0;
								next_r.st = smtc_pkg::ST_STROBE;
							end else if (rx_word.kind == smtc_pkg::K_RDCTRL) begin
								next_r.strb[rx_word.ctrl.sel] = 1'h0;
								next_r.st = smtc_pkg::ST_READ;
							end
						end
					end
					smtc_pkg::ST_STROBE: begin
						next_r.tcnt = 4'(r.tcnt + 4'h1);
						if (r.tcnt == STRB_LAST) begin
							next_r.strb = 2'h3;
							next_r.st = smtc_pkg::ST_IDLE;
						end
					end
					smtc_pkg::ST_READ: begin
						if (r.tcnt != RD_LAST) begin
							next_r.tcnt = 4'(r.tcnt + 4'h1);
						end else if (tx_ready) begin
							// Own rising strobe captures and returns data
							tx_valid = 1'h1;
							tx_word.kind = smtc_pkg::K_RDDATA;
							tx_word.data = r.s2.data;
							next_r.strb = 2'h3;
							next_r.st = smtc_pkg::ST_IDLE;
						end
					end
					default: begin
						next_r.st = smtc_pkg::ST_IDLE;
					end
				endcase
			end
		end
		if (!rst_n_i) begin
			next_r.fcnt = 4'h0;
			next_r.clr_act = 1'h0;
			next_r.mode = smtc_pkg::MODE_RESET;
			next_r.role = smtc_pkg::ROLE_MASTER;
			next_r.port = smtc_pkg::PORT_PAR;
			next_r.sel = 1'h0;
			next_r.st = smtc_pkg::ST_IDLE;
			next_r.tcnt = 4'h0;
			next_r.told = 1'h0;
			next_r.pd = '0;
			next_r.pc = '0;
			next_r.pdir = smtc_pkg::DIR_WRITE;
			next_r.strb = 2'h3;
			next_r.ch = 1'h0;
			next_r.act_prev = 1'h0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		r <= next_r;
	end

	// Pin drive: master pins off outside operation, slave always driving except its data pins in the read phase
	always_comb begin
		parallel_data_bus_oe_n_o = '1;
		control_lines_oe_n_o = '1;
		rw_dir_oe_n_o = 1'h1;
		strobe_out_oe_n_o = 2'h3;
		if (r.role == smtc_pkg::ROLE_MASTER) begin
			if (r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_DRIVE) begin
				parallel_data_bus_oe_n_o = '0;
			end
		end else begin
			control_lines_oe_n_o = '0;
			rw_dir_oe_n_o = 1'h0;
			strobe_out_oe_n_o = 2'h0;
			if (!(r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_READ)) begin
				parallel_data_bus_oe_n_o = '0;
			end
		end
	end

	assign parallel_data_bus_o = r.pd;
	assign control_lines_o = r.pc;
	assign rw_dir_o = r.pdir;
	assign strobe_out_0_o = r.strb[0];
	assign strobe_out_1_o = r.strb[1];
	assign mode_o = r.mode;

	// Checks
	logic clr_low, slv_low_power_request_n, got_sleep, rx_cs;
	logic [17:0] rx_data;
	assign clr_low = !r.s2.clear_n;
	assign slv_low_power_request_n = !r.role && r.mode == smtc_pkg::MODE_LOW_POWER_REQUEST_N;
	assign got_sleep = rx_valid && rx_word.kind == smtc_pkg::K_SLEEP;
	assign rx_cs = rx_word.data[0];
	assign rx_data = rx_word.data;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_CLR_FILTER: assert property (
		$rose(r.clr_act) |-> $past(clr_low, 1) && $past(clr_low, 4))
		else $error("Reset accepted without a full low run");
	AST_MST_PINS_OFF: assert property (
		r.role && r.mode != smtc_pkg::MODE_OPER |-> &parallel_data_bus_oe_n_o
		&& &control_lines_oe_n_o && rw_dir_oe_n_o && &strobe_out_oe_n_o)
		else $error("Master drives pins outside operation");
	AST_SLV_RESET_LOW: assert property (
		!r.role && r.mode == smtc_pkg::MODE_RESET |-> parallel_data_bus_o == '0
		&& control_lines_o == '0 && strobe_out_0_o && strobe_out_1_o
		&& parallel_data_bus_oe_n_o == '0)
		else $error("Slave reset levels wrong");
	AST_SLV_LOW_POWER_REQUEST_N_HOLD: assert property (
		slv_low_power_request_n && $past(slv_low_power_request_n) |-> $stable(r.pd) && $stable(r.pc) && r.strb == 2'h3)
		else $error("Slave standby does not hold");
	AST_SLV_LOW_POWER_REQUEST_N_CMD: assert property (
		$rose(slv_low_power_request_n) |-> $past(got_sleep))
		else $error("Slave standby without command");
	AST_MST_READ_START: assert property (
		r.role && r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_IDLE && !spi_sel
		&& !sleep_due && fell && r.s2.dir && tx_ready && !r.clr_act
		|-> tx_valid && tx_word.kind == smtc_pkg::K_RDCTRL && tx_word.data == '0
		##1 r.st == smtc_pkg::ST_READ)
		else $error("Read control not started");
	AST_SPI_NO_READ: assert property (
		r.role && spi_sel && tx_valid |-> tx_word.kind != smtc_pkg::K_RDCTRL
		&& tx_word.kind != smtc_pkg::K_WRITE)
		else $error("Parallel frame in SPI mode");
	AST_SPI_NO_DATA: assert property (
		tx_valid && tx_word.kind == smtc_pkg::K_SPI |-> tx_word.data[17:1] == '0)
		else $error("SPI frame carries data");
	AST_SLV_SPI_MIRROR: assert property (
		!r.role && r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_IDLE && rx_valid
		&& rx_word.kind == smtc_pkg::K_SPI && !r.clr_act |=> r.pd[6] == r.pc[5]
		&& r.pd[7] == r.pc[4] && strobe_out_0_o == $past(rx_cs))
		else $error("SPI pins not mirrored");
	AST_SLV_RD_FLOAT: assert property (
		!r.role && r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_IDLE && rx_valid
		&& rx_word.kind == smtc_pkg::K_RDCTRL && !r.clr_act
		|=> &parallel_data_bus_oe_n_o && !(&r.strb))
		else $error("Slave read phase start wrong");
	AST_SLV_RD_CAP: assert property (
		tx_valid && tx_word.kind == smtc_pkg::K_RDDATA && !r.clr_act
		|-> tx_word.data == r.s2.data ##1 r.strb == 2'h3)
		else $error("Read data capture wrong");
	AST_MST_DRIVE: assert property (
		r.role && r.mode == smtc_pkg::MODE_OPER && r.st == smtc_pkg::ST_READ && !sleep_due
		&& rx_valid && rx_word.kind == smtc_pkg::K_RDDATA && !r.clr_act && r.s2.lowpwr_n
		|=> parallel_data_bus_oe_n_o == '0 && parallel_data_bus_o == $past(rx_data))
		else $error("Master does not drive read data");
	AST_CFG_STATIC: assert property (
		r.mode != smtc_pkg::MODE_RESET && !r.clr_act |=> $stable({r.role, r.port, r.sel}))
		else $error("Configuration changed outside reset");
	COV_MST_READ: cover property (r.role && r.st == smtc_pkg::ST_DRIVE && rose);
	COV_SLV_WRITE: cover property (!r.role && r.st == smtc_pkg::ST_STROBE);
	COV_SPI: cover property (tx_valid && tx_word.kind == smtc_pkg::K_SPI);
	COV_SLV_LOW_POWER_REQUEST_N: cover property ($rose(slv_low_power_request_n));
endmodule // smtc_mode_ctrl

// *** smtc_display_model.sv ***
`timescale 1ns/1ns
// Display on the slave data pins: returns a fixed word when the slave reads
module smtc_display_model (
	input wire logic [1:0] strobe_i, // Slave strobes
	input wire logic [17:0] data_i, // Slave data out
	input wire logic [17:0] oe_n_i, // Slave data enables, low drives
	input wire logic [17:0] word_i, // Word to return
	output logic [17:0] pin_o // Level on the data pins
);
	logic on = 1'b0;
	logic [17:0] last = 18'h0_0000;
	// Word goes out after a strobe falls and is dropped after it rises
	always @(negedge strobe_i[0] or negedge strobe_i[1]) on <= 1'b1;
	always @(posedge strobe_i[0] or posedge strobe_i[1]) on <= #120 1'b0;
	always @(data_i) last = data_i;
	// Released pins never keep the old level
	assign pin_o = (data_i & ~oe_n_i) | ((on ? word_i : ~last) & oe_n_i);
endmodule // smtc_display_model

// *** smtc_mode_ctrl_test.sv ***
`timescale 1ns/1ns
module smtc_mode_ctrl_test;
	logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, clr_n = 1'b1, lp_n = 1'b1;
	logic port = 1'b1, sel = 1'b0, s0 = 1'b1, s1 = 1'b1, dir = 1'b0;
	logic [5:0] lines = 6'h00;
	logic [17:0] hdat = 18'h0_0000, word = 18'h1_3c5a;
	logic [17:0] m_do, m_doe, m_pin, s_do, s_doe, s_pin;
	logic [5:0] s_ctl;
	logic [1:0] m_soe, s_so, s_soe;
	logic s_dir, m2s, s2m;
	smtc_pkg::smtc_mode_e m_mode, s_mode;
	int n_fail = 0, total_checks = 0;
	// System clock and an unrelated link clock
	always #25 clk = ~clk;
	always begin
		#62 lclk = 1'b1;
		#63 lclk = 1'b0;
	end
	// Master data pins: host drives while the master is off them
	assign m_pin = (hdat & m_doe) | (m_do & ~m_doe);
	smtc_mode_ctrl u_smtc_mode_ctrl_m (.sys_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk),
		.link_data_i(s2m), .link_data_o(m2s), .role_select_i(1'b1), .chip_clear_n_i(clr_n),
		.low_power_request_n_i(lp_n), .port_mode_select_i(port), .strobe_source_select_i(sel),
		.strobe_in_0_i(s0), .strobe_in_1_i(s1), .strobe_out_0_o(), .strobe_out_1_o(),
		.strobe_out_oe_n_o(m_soe), .parallel_data_bus_i(m_pin), .parallel_data_bus_o(m_do),
		.parallel_data_bus_oe_n_o(m_doe), .control_lines_i(lines), .control_lines_o(),
		.control_lines_oe_n_o(), .rw_dir_i(dir), .rw_dir_o(), .rw_dir_oe_n_o(), .mode_o(m_mode));
	smtc_mode_ctrl u_smtc_mode_ctrl_s (.sys_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk),
		.link_data_i(m2s), .link_data_o(s2m), .role_select_i(1'b0), .chip_clear_n_i(clr_n),
		.low_power_request_n_i(1'b1), .port_mode_select_i(port), .strobe_source_select_i(1'b0),
		.strobe_in_0_i(s_so[0]), .strobe_in_1_i(s_so[1]), .strobe_out_0_o(s_so[0]),
		.strobe_out_1_o(s_so[1]), .strobe_out_oe_n_o(s_soe), .parallel_data_bus_i(s_pin),
		.parallel_data_bus_o(s_do), .parallel_data_bus_oe_n_o(s_doe), .control_lines_i(s_ctl),
		.control_lines_o(s_ctl), .control_lines_oe_n_o(), .rw_dir_i(s_dir), .rw_dir_o(s_dir),
		.rw_dir_oe_n_o(), .mode_o(s_mode));
	smtc_display_model u_smtc_display_model (.strobe_i(s_so), .data_i(s_do), .oe_n_i(s_doe),
		.word_i(word), .pin_o(s_pin));
	// Helpers for stepping, comparing and bounded waiting
	task tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function logic cond(input int k);
		case (k)
			0: return s_so[0];
			1: return s_so[1];
			2: return m_doe[0];
			3: return s_ctl[4];
			4: return m_mode === smtc_pkg::MODE_LOW_POWER_REQUEST_N;
			5: return s_mode === smtc_pkg::MODE_LOW_POWER_REQUEST_N;
			default: return s_mode === smtc_pkg::MODE_OPER;
		endcase
	endfunction
	task wait_for(input int k, input logic v);
		for (int i = 0; i < 600 && cond(k) !== v; i++) tick(1);
		// A wait that runs out counts as a mismatch
		chk(18'(cond(k)), 18'(v));
	endtask
	task do_reset(input logic p, input logic s, input int n);
		rst_n = 1'b0;
		port = p;
		sel = s;
		tick(n);
		rst_n = 1'b1;
		tick(16);
	endtask
	// Parallel write on one strobe channel, seen on the slave port
	task host_write(input logic [17:0] d, input logic [5:0] l, input int ch);
		hdat = d;
		lines = l;
		dir = smtc_pkg::DIR_WRITE;
		tick(2);
		if (ch == 0) s0 = 1'b0; else s1 = 1'b0;
		wait_for(ch, 1'b0);
		chk(s_do, d);
		chk(18'(s_ctl), 18'(l));
		chk(18'(s_dir), 18'h0_0000);
		tick(4);
		chk(18'(s_so), 18'h0_0003);
		if (ch == 0) s0 = 1'b1; else s1 = 1'b1;
		tick(100);
	endtask
	task print_verdict;
		if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_fail++;
		print_verdict;
	end
	initial begin
		do_reset(1'b1, 1'b0, 4);
		chk(18'(m_soe), 18'h0_0003);
		chk(18'(s_soe), 18'h0_0000);
		chk(18'(m_mode), 18'(smtc_pkg::MODE_OPER));
		// Short clear pulse is ignored, a long one resets both ends
		clr_n = 1'b0;
		tick(2);
		clr_n = 1'b1;
		tick(8);
		chk(18'(m_mode), 18'(smtc_pkg::MODE_OPER));
		clr_n = 1'b0;
		tick(10);
		chk(18'(s_mode), 18'(smtc_pkg::MODE_RESET));
		chk(s_do, 18'h0_0000);
		chk(18'(s_so), 18'h0_0003);
		chk(m_doe, 18'h3_ffff);
		clr_n = 1'b1;
		tick(10);
		host_write(18'h2_a5c3, 6'h15, 0);
		// Two-phase read with data bits on the host side that must be ignored
		hdat = 18'h3_0f0f;
		lines = 6'h2d;
		tick(1);
		dir = smtc_pkg::DIR_READ;
		tick(2);
		s0 = 1'b0;
		wait_for(0, 1'b0);
		chk(s_doe, 18'h3_ffff);
		chk(18'(s_ctl), 18'h0_002d);
		chk(18'(s_dir), 18'h0_0001);
		wait_for(2, 1'b0);
		chk(m_do, word);
		chk(m_doe, 18'h0_0000);
		s0 = 1'b1;
		tick(4);
		chk(m_doe, 18'h3_ffff);
		dir = smtc_pkg::DIR_WRITE;
		tick(100);
		host_write(18'h1_5a3c, 6'h2a, 0);
		// Standby travels over the link; slave keeps its last word
		lp_n = 1'b0;
		wait_for(4, 1'b1);
		chk(m_doe, 18'h3_ffff);
		wait_for(5, 1'b1);
		chk(s_do, 18'h1_5a3c);
		chk(18'(s_so), 18'h0_0003);
		lp_n = 1'b1;
		wait_for(6, 1'b1);
		tick(100);
		do_reset(1'b1, 1'b1, 8);
		host_write(18'h0_0f0f, 6'h03, 1);
		// SPI write: chip select on strobe 0, clock on line 5, data on line 4
		do_reset(1'b0, 1'b0, 8);
		s0 = 1'b0;
		lines = 6'h10;
		tick(4);
		lines = 6'h30;
		wait_for(3, 1'b1);
		chk(18'(s_ctl[5:4]), 18'h0_0003);
		chk(18'(s_do[7:6]), 18'h0_0003);
		chk(18'(s_so[0]), 18'h0_0000);
		print_verdict;
	end
endmodule // smtc_mode_ctrl_test
